// ### chan_regs.sv
// One channel's register set: reset controls and sticky loss indicators
`timescale 1ns/1ps
`default_nettype none
module chan_regs
  import chsel_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic cdr_lock,
  input wire logic sig_detect,
  output logic [7:0] rdata,
  output chan_resets_t resets
);
  logic [3:0] ctrl_reg;
  logic lock_lost_reg;
  logic sig_lost_reg;
  logic lock_seen_reg;
  logic sig_seen_reg;
  logic cdr_lock_d_reg;
  logic sig_detect_d_reg;
  logic soft_rst;
  logic lock_fall;
  logic sig_fall;

  // ----------------------------------------
  // Register set reset and edge detect
  // ----------------------------------------
  assign soft_rst = ctrl_reg[REGS_RST_BIT];
  assign lock_fall = cdr_lock_d_reg && !cdr_lock && lock_seen_reg;
  assign sig_fall = sig_detect_d_reg && !sig_detect && sig_seen_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cdr_lock_d_reg <= 1'b0;
      sig_detect_d_reg <= 1'b0;
    end else begin
      cdr_lock_d_reg <= cdr_lock;
      sig_detect_d_reg <= sig_detect;
    end
  end

  // ----------------------------------------
  // Reset controls
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= RESET_CONTROLS_RESET[3:0];
    end else if (soft_rst) begin
      ctrl_reg <= RESET_CONTROLS_RESET[3:0];
    end else if (wr_en && addr == ADDR_RESET_CONTROLS) begin
      ctrl_reg <= wdata[3:0];
    end
  end

  // ----------------------------------------
  // Loss indicators
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_seen_reg <= 1'b0;
      sig_seen_reg <= 1'b0;
      lock_lost_reg <= LOSS_INDICATORS_RESET[LOCK_LOST_BIT];
      sig_lost_reg <= LOSS_INDICATORS_RESET[SIG_LOST_BIT];
    end else if (soft_rst) begin
      lock_seen_reg <= 1'b0;
      sig_seen_reg <= 1'b0;
      lock_lost_reg <= LOSS_INDICATORS_RESET[LOCK_LOST_BIT];
      sig_lost_reg <= LOSS_INDICATORS_RESET[SIG_LOST_BIT];
    end else begin
      if (cdr_lock) begin
        lock_seen_reg <= 1'b1;
      end
      if (sig_detect) begin
        sig_seen_reg <= 1'b1;
      end
      if (lock_fall) begin
        lock_lost_reg <= 1'b1;
      end else if (rd_en && addr == ADDR_LOSS_INDICATORS) begin
        lock_lost_reg <= 1'b0;
      end
      if (sig_fall) begin
        sig_lost_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata = 8'h00;
    if (addr == ADDR_RESET_CONTROLS) begin
      rdata = {4'h0, ctrl_reg};
    end else if (addr == ADDR_LOSS_INDICATORS) begin
      rdata = {3'h0, lock_lost_reg, 3'h0, sig_lost_reg};
    end
  end

  assign resets.core_reset = ctrl_reg[CORE_RST_BIT];
  assign resets.regs_reset = ctrl_reg[REGS_RST_BIT];
  assign resets.ref_domain_reset = ctrl_reg[REF_RST_BIT];
  assign resets.osc_div_domain_reset = ctrl_reg[OSC_RST_BIT];

  property p_lock_lost_sets;
    @(posedge sys_clk) disable iff (rst)
      (lock_fall && !soft_rst) |=> lock_lost_reg;
  endproperty
  a_lock_lost_sets: assert property (p_lock_lost_sets)
    else $error("lock loss flag not set");

  property p_lock_clear_on_read;
    @(posedge sys_clk) disable iff (rst)
      (rd_en && addr == ADDR_LOSS_INDICATORS && !lock_fall) |=> !lock_lost_reg;
  endproperty
  a_lock_clear_on_read: assert property (p_lock_clear_on_read)
    else $error("lock loss flag not cleared by read");

  property p_sig_lost_sticky;
    @(posedge sys_clk) disable iff (rst)
      (sig_lost_reg && !soft_rst) |=> sig_lost_reg;
  endproperty
  a_sig_lost_sticky: assert property (p_sig_lost_sticky)
    else $error("signal loss flag dropped");

  property p_soft_reset_clears;
    @(posedge sys_clk) disable iff (rst)
      soft_rst |=> (ctrl_reg == 4'h0 && !lock_lost_reg && !sig_lost_reg);
  endproperty
  a_soft_reset_clears: assert property (p_soft_reset_clears)
    else $error("register set reset did not restore defaults");
endmodule // chan_regs
`default_nettype wire

// ### channel_register_set_selector_bench.sv
// Self-checking bench for the channel register set selector
`timescale 1ns/1ps
`default_nettype none
module channel_register_set_selector_bench;
  import chsel_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  reg_access_t acc;
  logic [7:0] shared_rdata, rdata, shared_addr, shared_wdata;
  logic shared_wr, shared_rd;
  logic [3:0] cdr_lock = 4'h0;
  logic [3:0] sig_detect = 4'h0;
  logic [3:0] core_reset, ref_domain_reset, osc_div_domain_reset;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int sel = 0;
  int ctrl[4] = '{default: 0};
  int lf[4] = '{default: 0};
  int sf[4] = '{default: 0};
  always #10 sys_clk = ~sys_clk;
  assign shared_rdata = acc.addr ^ 8'h5a;
  chsel_top dut (.sys_clk(sys_clk), .rst(rst), .access(acc),
    .shared_rdata(shared_rdata), .cdr_lock(cdr_lock),
    .sig_detect(sig_detect), .rdata(rdata), .shared_wr(shared_wr),
    .shared_rd(shared_rd), .shared_addr(shared_addr),
    .shared_wdata(shared_wdata), .core_reset(core_reset),
    .ref_domain_reset(ref_domain_reset),
    .osc_div_domain_reset(osc_div_domain_reset));
  host_model host (.sys_clk(sys_clk), .rdata(rdata), .access(acc));
  // ------------------------------------------------
  // Compare, close and watchdog
  // ------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ------------------------------------------------
  // Accesses against the reference model
  // ------------------------------------------------
  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic sh;
    sh = !sel[2] && a != 8'hff;
    if (a == 8'hff) host.sel_write(d[3:0]);
    else host.xfer(1'b1, a, d, q);
    check({7'h0, shared_wr}, {7'h0, sh});
    if (sh) check(shared_addr, a);
    if (sh) check(shared_wdata, d);
    if (a == 8'hff) sel = d[3:0];
    else if (sel[2] && a == 8'h00) begin
      for (int c = 0; c < 4; c++) begin
        if (sel[3] || c == sel[1:0]) begin
          ctrl[c] = d[2] ? 0 : d & 8'h0b;
          lf[c] = d[2] ? 0 : lf[c];
          sf[c] = d[2] ? 0 : sf[c];
        end
      end
    end
    @(posedge sys_clk);
    #1;
    for (int c = 0; c < 4; c++) begin
      check({core_reset[c], 1'b0, ref_domain_reset[c],
        osc_div_domain_reset[c]}, 8'(ctrl[c]));
    end
  endtask
  task automatic do_rd(input logic [7:0] a);
    logic [7:0] q;
    logic [7:0] e;
    int c;
    c = sel & 3;
    host.xfer(1'b0, a, 8'h00, q);
    check({7'h0, shared_rd}, {7'h0, !sel[2] && a != 8'hff});
    if (a == 8'hff) e = SELECTOR_READ_VALUE;
    else if (!sel[2]) e = a ^ 8'h5a;
    else if (a == 8'h00) e = 8'(ctrl[c]);
    else begin
      e = 8'((lf[c] << 4) | sf[c]);
      lf[c] = 0;
    end
    check(q, e);
  endtask
  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(32'hb824f5f8));
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    do_rd(8'hff);
    repeat (4) begin
      logic [7:0] a;
      a = 8'($urandom % 255);
      do_wr(a, 8'($urandom));
      do_rd(a);
    end
    $display("test shared done");
    host.gap_max = 2;
    for (int c = 0; c < 4; c++) begin
      do_wr(8'hff, 8'(4 + c));
      do_wr(8'h00, 8'($urandom) & 8'hfb);
      do_rd(8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      do_wr(8'hff, 8'(4 + c));
      do_rd(8'h00);
    end
    $display("test single channel done");
    for (int s = 12; s < 16; s++) begin
      do_wr(8'hff, 8'(s));
      do_wr(8'h00, 8'($urandom) & 8'hfb);
      do_rd(8'h00);
    end
    do_wr(8'hff, 8'h00);
    do_rd(8'h10);
    $display("test broadcast done");
    for (int c = 0; c < 4; c++) begin
      do_wr(8'hff, 8'(4 + c));
      @(posedge sys_clk);
      #1;
      cdr_lock[c] = 1'b1;
      sig_detect[c] = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      cdr_lock[c] = 1'b0;
      sig_detect[c] = 1'b0;
      lf[c] = 1;
      sf[c] = 1;
      repeat (3) @(posedge sys_clk);
      do_wr(8'h01, 8'hff);
      do_rd(8'h01);
      do_rd(8'h01);
    end
    $display("test loss flags done");
    do_wr(8'hff, 8'h0e);
    do_wr(8'h00, 8'h0b);
    do_wr(8'h00, 8'h04);
    for (int c = 0; c < 4; c++) begin
      do_wr(8'hff, 8'(4 + c));
      do_rd(8'h00);
      do_rd(8'h01);
    end
    $display("test register reset done");
    wrap_up();
  end
endmodule // channel_register_set_selector_bench
`default_nettype wire

// ### chsel_pkg.sv
// Constants and types for the channel register set selector
package chsel_pkg;
  localparam logic [7:0] ADDR_RESET_CONTROLS = 8'h00;
  localparam logic [7:0] ADDR_LOSS_INDICATORS = 8'h01;
  localparam logic [7:0] ADDR_SELECTOR = 8'hff;
  localparam logic [7:0] SELECTOR_RESET = 8'h00;
  localparam logic [7:0] SELECTOR_READ_VALUE = 8'h00;
  localparam logic [7:0] RESET_CONTROLS_RESET = 8'h00;
  localparam logic [7:0] LOSS_INDICATORS_RESET = 8'h00;
  localparam logic [7:0] RESET_CONTROLS_MASK = 8'h0f;
  localparam int SEL_CH_LSB = 0;
  localparam int SEL_EN_BIT = 2;
  localparam int SEL_BCAST_BIT = 3;
  localparam int CORE_RST_BIT = 3;
  localparam int REGS_RST_BIT = 2;
  localparam int REF_RST_BIT = 1;
  localparam int OSC_RST_BIT = 0;
  localparam int LOCK_LOST_BIT = 4;
  localparam int SIG_LOST_BIT = 0;
  localparam int NUM_CHANNELS = 4;

  typedef struct packed {
    logic broadcast;
    logic enable;
    logic [1:0] channel;
  } selector_t;

  typedef struct packed {
    logic core_reset;
    logic regs_reset;
    logic ref_domain_reset;
    logic osc_div_domain_reset;
  } chan_resets_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;
endpackage

// ### chsel_top.sv
// Shared selector and steering of accesses to four channel register sets
`timescale 1ns/1ps
`default_nettype none
module chsel_top
  import chsel_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire reg_access_t access,
  input wire logic [7:0] shared_rdata,
  input wire logic [CHANNELS-1:0] cdr_lock,
  input wire logic [CHANNELS-1:0] sig_detect,
  output logic [7:0] rdata,
  output logic shared_wr,
  output logic shared_rd,
  output logic [7:0] shared_addr,
  output logic [7:0] shared_wdata,
  output logic [CHANNELS-1:0] core_reset,
  output logic [CHANNELS-1:0] ref_domain_reset,
  output logic [CHANNELS-1:0] osc_div_domain_reset
);
  selector_t sel_reg;
  logic is_sel;
  logic [CHANNELS-1:0] ch_wr;
  logic [CHANNELS-1:0] ch_rd;
  logic [7:0] ch_rdata [CHANNELS];
  chan_resets_t ch_resets [CHANNELS];
  logic [7:0] rdata_next;

  function automatic logic hit(input selector_t s, input int ch);
    hit = s.enable && (s.channel == ch[1:0]);
  endfunction

  function automatic logic to_shared(input selector_t s, input logic at_sel);
    to_shared = !at_sel && !s.enable;
  endfunction

  // ----------------------------------------
  // Selector
  // ----------------------------------------
  assign is_sel = access.addr == ADDR_SELECTOR;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_reg <= SELECTOR_RESET[3:0];
    end else if (access.wr && is_sel) begin
      sel_reg <= access.wdata[3:0];
    end
  end

  // ----------------------------------------
  // Steering
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      ch_wr[i] = access.wr && !is_sel && sel_reg.enable &&
        (sel_reg.broadcast || hit(sel_reg, i));
      ch_rd[i] = access.rd && !is_sel && hit(sel_reg, i);
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      chan_regs u_chan (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(ch_wr[g]),
        .rd_en(ch_rd[g]),
        .addr(access.addr),
        .wdata(access.wdata),
        .cdr_lock(cdr_lock[g]),
        .sig_detect(sig_detect[g]),
        .rdata(ch_rdata[g]),
        .resets(ch_resets[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    if (is_sel) begin
      rdata_next = SELECTOR_READ_VALUE;
    end else if (sel_reg.enable) begin
      rdata_next = ch_rdata[sel_reg.channel];
    end else begin
      rdata_next = shared_rdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (access.rd) begin
      rdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // Shared set port
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shared_wr <= 1'b0;
      shared_rd <= 1'b0;
      shared_addr <= 8'h00;
      shared_wdata <= 8'h00;
    end else begin
      shared_wr <= access.wr && to_shared(sel_reg, is_sel);
      shared_rd <= access.rd && to_shared(sel_reg, is_sel);
      shared_addr <= access.addr;
      shared_wdata <= access.wdata;
    end
  end

  // ----------------------------------------
  // Channel reset outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_reset <= '0;
      ref_domain_reset <= '0;
      osc_div_domain_reset <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        core_reset[i] <= ch_resets[i].core_reset;
        ref_domain_reset[i] <= ch_resets[i].ref_domain_reset;
        osc_div_domain_reset[i] <= ch_resets[i].osc_div_domain_reset;
      end
    end
  end

  // ----------------------------------------
  // Per-channel checks
  // ----------------------------------------
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chk
      property p_core_follow;
        @(posedge sys_clk) disable iff (rst)
          1'b1 |=> (core_reset[g] == $past(ch_resets[g].core_reset));
      endproperty
      a_core_follow: assert property (p_core_follow)
        else $error("core reset output lags its control bit");

      property p_ref_follow;
        @(posedge sys_clk) disable iff (rst)
          1'b1 |=>
            (ref_domain_reset[g] == $past(ch_resets[g].ref_domain_reset));
      endproperty
      a_ref_follow: assert property (p_ref_follow)
        else $error("reference domain reset lags its control bit");

      property p_osc_follow;
        @(posedge sys_clk) disable iff (rst)
          1'b1 |=> (osc_div_domain_reset[g] ==
            $past(ch_resets[g].osc_div_domain_reset));
      endproperty
      a_osc_follow: assert property (p_osc_follow)
        else $error("divided oscillator reset lags its control bit");

      property p_regs_clear;
        @(posedge sys_clk) disable iff (rst)
          ch_resets[g].regs_reset |-> ##2 (!core_reset[g] &&
            !ref_domain_reset[g] && !osc_div_domain_reset[g]);
      endproperty
      a_regs_clear: assert property (p_regs_clear)
        else $error("register set reset left a reset output set");

      property p_write_reaches;
        @(posedge sys_clk) disable iff (rst)
          (access.wr && !is_sel && sel_reg.enable && sel_reg.channel == g)
            |-> ch_wr[g];
      endproperty
      a_write_reaches: assert property (p_write_reaches)
        else $error("write missed the selected channel");

      property p_bcast_reaches;
        @(posedge sys_clk) disable iff (rst)
          (access.wr && !is_sel && sel_reg.enable && sel_reg.broadcast)
            |-> ch_wr[g];
      endproperty
      a_bcast_reaches: assert property (p_bcast_reaches)
        else $error("broadcast write missed this channel");

      property p_write_stays_out;
        @(posedge sys_clk) disable iff (rst)
          (access.wr && !sel_reg.broadcast && sel_reg.channel != g)
            |-> !ch_wr[g];
      endproperty
      a_write_stays_out: assert property (p_write_stays_out)
        else $error("single channel write reached another channel");

      property p_read_reaches;
        @(posedge sys_clk) disable iff (rst)
          (access.rd && !is_sel && sel_reg.enable && sel_reg.channel == g)
            |-> ch_rd[g];
      endproperty
      a_read_reaches: assert property (p_read_reaches)
        else $error("read missed the selected channel");

      property p_read_stays_out;
        @(posedge sys_clk) disable iff (rst)
          (sel_reg.channel != g) |-> !ch_rd[g];
      endproperty
      a_read_stays_out: assert property (p_read_stays_out)
        else $error("read reached an unselected channel");
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sel_write;
    @(posedge sys_clk) disable iff (rst)
      (access.wr && is_sel) |=> (sel_reg == $past(access.wdata[3:0]));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("selector not updated by write");

  property p_sel_hold;
    @(posedge sys_clk) disable iff (rst)
      !(access.wr && is_sel) |=> $stable(sel_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("selector changed without a write");

  property p_shared_when_off;
    @(posedge sys_clk) disable iff (rst)
      (!sel_reg.enable && access.wr && !is_sel)
        |-> (ch_wr == '0) ##1 shared_wr;
  endproperty
  a_shared_when_off: assert property (p_shared_when_off)
    else $error("write not steered to shared set");

  property p_channel_when_on;
    @(posedge sys_clk) disable iff (rst)
      (sel_reg.enable && access.wr) |=> !shared_wr;
  endproperty
  a_channel_when_on: assert property (p_channel_when_on)
    else $error("shared set written while channel enabled");

  property p_broadcast;
    @(posedge sys_clk) disable iff (rst)
      (sel_reg.enable && sel_reg.broadcast && access.wr && !is_sel)
        |-> (&ch_wr);
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("broadcast write missed a channel");

  property p_read_one;
    @(posedge sys_clk) disable iff (rst)
      (sel_reg.enable && access.rd && !is_sel)
        |-> ($onehot(ch_rd) && ch_rd[sel_reg.channel])
        ##1 (rdata == $past(ch_rdata[sel_reg.channel]));
  endproperty
  a_read_one: assert property (p_read_one)
    else $error("channel read not from selected channel");

  property p_no_chan_ff;
    @(posedge sys_clk) disable iff (rst)
      is_sel |-> (ch_wr == '0 && ch_rd == '0) ##1 !shared_wr;
  endproperty
  a_no_chan_ff: assert property (p_no_chan_ff)
    else $error("address register_set_selector reached a channel set");

  property p_sel_read;
    @(posedge sys_clk) disable iff (rst)
      (access.rd && is_sel) |=> (rdata == SELECTOR_READ_VALUE);
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("selector read gave other than fixed value");

  property p_sel_wr_not_shared;
    @(posedge sys_clk) disable iff (rst)
      (access.wr && is_sel) |=> !shared_wr;
  endproperty
  a_sel_wr_not_shared: assert property (p_sel_wr_not_shared)
    else $error("selector write leaked to the shared set");

  property p_shared_rd_when_off;
    @(posedge sys_clk) disable iff (rst)
      (!sel_reg.enable && access.rd && !is_sel) |=> shared_rd;
  endproperty
  a_shared_rd_when_off: assert property (p_shared_rd_when_off)
    else $error("read not steered to shared set");

  property p_no_shared_rd_when_on;
    @(posedge sys_clk) disable iff (rst)
      (sel_reg.enable || is_sel) |=> !shared_rd;
  endproperty
  a_no_shared_rd_when_on: assert property (p_no_shared_rd_when_on)
    else $error("shared set read while channel enabled");

  property p_shared_addr_copy;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> (shared_addr == $past(access.addr));
  endproperty
  a_shared_addr_copy: assert property (p_shared_addr_copy)
    else $error("shared address not a copy of the access");

  property p_shared_wdata_copy;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> (shared_wdata == $past(access.wdata));
  endproperty
  a_shared_wdata_copy: assert property (p_shared_wdata_copy)
    else $error("shared write data not a copy of the access");

  property p_shared_rdata_pass;
    @(posedge sys_clk) disable iff (rst)
      (!sel_reg.enable && access.rd && !is_sel)
        |=> (rdata == $past(shared_rdata));
  endproperty
  a_shared_rdata_pass: assert property (p_shared_rdata_pass)
    else $error("shared read data not returned");

  property p_rdata_hold;
    @(posedge sys_clk) disable iff (rst)
      !access.rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_off_no_channel;
    @(posedge sys_clk) disable iff (rst)
      !sel_reg.enable |-> (ch_wr == '0 && ch_rd == '0);
  endproperty
  a_off_no_channel: assert property (p_off_no_channel)
    else $error("channel set reached with enable clear");

  property p_single_write;
    @(posedge sys_clk) disable iff (rst)
      (sel_reg.enable && !sel_reg.broadcast && access.wr && !is_sel)
        |-> $onehot(ch_wr);
  endproperty
  a_single_write: assert property (p_single_write)
    else $error("single channel write did not reach exactly one set");

  property p_bcast_read_one;
    @(posedge sys_clk) disable iff (rst)
      (sel_reg.enable && sel_reg.broadcast && access.rd && !is_sel)
        |-> ($countones(ch_rd) == 1);
  endproperty
  a_bcast_read_one: assert property (p_bcast_read_one)
    else $error("broadcast read touched more than one channel");
endmodule // chsel_top
`default_nettype wire

// ### host_model.sv
// Host controller model issuing register accesses to the selector block
`timescale 1ns/1ps
`default_nettype none
module host_model
  import chsel_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output reg_access_t access
);
  int gap_max = 0;
  initial access = '0;
  // ------------------------------------------------
  // One access, held up to its taking edge
  // ------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int gap;
    gap = $urandom % (gap_max + 1);
    repeat (gap + 1) @(posedge sys_clk);
    #1;
    access.wr = w;
    access.rd = !w;
    access.addr = a;
    access.wdata = w ? d : 8'h00;
    @(posedge sys_clk);
    #1;
    access = '0;
    q = rdata;
  endtask
  // Selector write with all bits given and upper nibble zero
  task automatic sel_write(input logic [3:0] v);
    logic [7:0] q;
    xfer(1'b1, ADDR_SELECTOR, {4'h0, v}, q);
  endtask
endmodule // host_model
`default_nettype wire
